// [adcrs_defines.svh]
// constants of the routine sequencer: field sizes, trigger codes, timing counts
// assumes inclusion by bare name from the trigger and sequencer module source files
`ifndef ADCRS_DEFINES_SVH
`define ADCRS_DEFINES_SVH

`define ADCRS_CH_W 5
`define ADCRS_RES_W 12
`define ADCRS_DATA_W 16
`define ADCRS_SLOTS 16
`define ADCRS_SLOT_W 4
`define ADCRS_NUM_CH 18
`define ADCRS_SMP_W 3
`define ADCRS_GRP_W 3
`define ADCRS_CNT_W 9
`define ADCRS_PAD_W 4

// sample durations per sample-time code, in conversion-clock cycles
`define ADCRS_SMP_CYC_0 9'h002
`define ADCRS_SMP_CYC_1 9'h004
`define ADCRS_SMP_CYC_2 9'h008
`define ADCRS_SMP_CYC_3 9'h010
`define ADCRS_SMP_CYC_4 9'h020
`define ADCRS_SMP_CYC_5 9'h040
`define ADCRS_SMP_CYC_6 9'h080
`define ADCRS_SMP_CYC_7 9'h100

// conversion takes 12.5 cycles at 12 bits, kept in half cycles, rounded up
`define ADCRS_CONV_HALF_CYC 25
`define ADCRS_CONV_CYC 9'((`ADCRS_CONV_HALF_CYC + 1) / 2)

// hardware trigger select codes
`define ADCRS_TRG_TA0 3'h0
`define ADCRS_TRG_TA1 3'h1
`define ADCRS_TRG_TA2 3'h2
`define ADCRS_TRG_TB1 3'h3
`define ADCRS_TRG_TCO 3'h4
`define ADCRS_TRG_TD3 3'h5
`define ADCRS_TRG_EXT 3'h6

`define ADCRS_DATA_RST 16'h0000

`endif

// [adcrs_pkg.sv]
// types of the routine sequencer
// assumes nothing beyond a SystemVerilog compiler
package adcrs_pkg;

	typedef enum logic [1:0] {
		ADCRS_IDLE,
		ADCRS_SAMPLE,
		ADCRS_CONVERT
	} adcrs_state_t;

endpackage

// [adcrs_trig.sv]
// hardware trigger source selection and rising edge detection
// assumes trigger sources synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "adcrs_defines.svh"

module adcrs_trig (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hold_clear,
	input wire logic [2:0] hw_trigger_select,
	input wire logic timer_a_compare_0,
	input wire logic timer_a_compare_1,
	input wire logic timer_a_compare_2,
	input wire logic timer_b_compare_1,
	input wire logic timer_c_trigger_out,
	input wire logic timer_d_compare_3,
	input wire logic ext_line_eleven,
	output logic rise
);

	logic sel_level;
	logic prev_level;

	always_comb begin
		case (hw_trigger_select)
			`ADCRS_TRG_TA0: sel_level = timer_a_compare_0;
			`ADCRS_TRG_TA1: sel_level = timer_a_compare_1;
			`ADCRS_TRG_TA2: sel_level = timer_a_compare_2;
			`ADCRS_TRG_TB1: sel_level = timer_b_compare_1;
			`ADCRS_TRG_TCO: sel_level = timer_c_trigger_out;
			`ADCRS_TRG_TD3: sel_level = timer_d_compare_3;
			`ADCRS_TRG_EXT: sel_level = ext_line_eleven;
			default: sel_level = 1'b0;
		endcase
	end

	// switching the select onto a high source counts as an edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_level <= 1'b0;
		end else if (hold_clear) begin
			prev_level <= 1'b0;
		end else begin
			prev_level <= sel_level;
		end
	end

	assign rise = sel_level & ~prev_level;

endmodule
`default_nettype wire

// [adcrs_seq.sv]
// routine sequencer of a successive-approximation converter: modes, timing,
// result alignment, done flag, limit watch and transfer requests
// assumes all control inputs synchronous to clk, which is the conversion clock
//
// How it works
// - single mode converts first slot once per trigger
// - start needs enable and an active trigger
// - software start acts like hardware trigger
// - channel end stores data, sets done in single mode
// - software clear pulse drops done flag
// - repeat mode reconverts channel without triggers
// - scan converts slots 0 to length field per trigger
// - scan sets done only after sequence end
// - scan plus repeat restarts sequence automatically
// - discontinuous converts next group per trigger
// - discontinuous sets done after full pass
// - out-of-window result sets limit flag
// - window compare uses raw unaligned result
// - watch one chosen channel or all
// - alignment bit picks right or left
// - each channel has own sample time
// - conversion lasts sample plus 13 cycles (12.5 rounded up)
// - hardware trigger acts on rising edge
// - select code picks trigger source
// - enable low holds everything in reset
// - sequence holds sixteen slots, length field
// - transfer request after every channel end
`timescale 1ns/100ps
`default_nettype none
`include "adcrs_defines.svh"

module adcrs_seq (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic converter_enable,
	input wire logic scan_enable,
	input wire logic repeat_enable,
	input wire logic discontinuous_enable,
	input wire logic [`ADCRS_GRP_W-1:0] group_size,
	input wire logic [`ADCRS_SLOT_W-1:0] sequence_length,
	input wire logic [`ADCRS_SLOTS*`ADCRS_CH_W-1:0] sequence_slots,
	input wire logic [`ADCRS_NUM_CH*`ADCRS_SMP_W-1:0] sample_time_regs,
	input wire logic hw_trigger_enable,
	input wire logic [2:0] hw_trigger_select,
	input wire logic soft_routine_start,
	input wire logic timer_a_compare_0,
	input wire logic timer_a_compare_1,
	input wire logic timer_a_compare_2,
	input wire logic timer_b_compare_1,
	input wire logic timer_c_trigger_out,
	input wire logic timer_d_compare_3,
	input wire logic ext_line_eleven,
	input wire logic align_select,
	input wire logic dma_enable,
	input wire logic done_irq_enable,
	input wire logic done_flag_clear,
	input wire logic routine_watch_enable,
	input wire logic single_channel_watch,
	input wire logic [`ADCRS_CH_W-1:0] watched_channel,
	input wire logic [`ADCRS_RES_W-1:0] high_limit_reg,
	input wire logic [`ADCRS_RES_W-1:0] low_limit_reg,
	input wire logic limit_irq_enable,
	input wire logic limit_flag_clear,
	input wire logic [`ADCRS_RES_W-1:0] ana_result,
	output logic [`ADCRS_CH_W-1:0] ana_channel,
	output logic ana_sample,
	output logic ana_convert,
	output logic [`ADCRS_DATA_W-1:0] routine_data,
	output logic done_flag,
	output logic limit_violation_flag,
	output logic dma_request,
	output logic irq,
	output logic busy
);

	adcrs_pkg::adcrs_state_t state;
	adcrs_pkg::adcrs_state_t next_state;
	logic [`ADCRS_SLOT_W-1:0] slot;
	logic [`ADCRS_SLOT_W-1:0] next_slot;
	logic [`ADCRS_GRP_W-1:0] group_cnt;
	logic [`ADCRS_GRP_W-1:0] next_group_cnt;
	logic [`ADCRS_CNT_W-1:0] cnt;
	logic [`ADCRS_CNT_W-1:0] next_cnt;
	logic hw_rise;
	logic trigger;
	logic chan_end;
	logic seq_last;
	logic set_done;
	logic [`ADCRS_CH_W-1:0] cur_channel;
	logic [`ADCRS_CH_W-1:0] next_channel;
	logic watch_hit;
	logic outside;

	// channel number held in a sequence slot
	function automatic logic [`ADCRS_CH_W-1:0] slot_channel(
		input logic [`ADCRS_SLOTS*`ADCRS_CH_W-1:0] slots,
		input logic [`ADCRS_SLOT_W-1:0] idx
	);
		slot_channel = slots[idx*`ADCRS_CH_W +: `ADCRS_CH_W];
	endfunction

	// sampling duration of a channel, from its own sample-time code
	function automatic logic [`ADCRS_CNT_W-1:0] sample_cycles(
		input logic [`ADCRS_NUM_CH*`ADCRS_SMP_W-1:0] times,
		input logic [`ADCRS_CH_W-1:0] ch
	);
		logic [`ADCRS_SMP_W-1:0] code;
		code = 3'h0;
		if (ch < 5'(`ADCRS_NUM_CH)) begin
			code = times[ch*`ADCRS_SMP_W +: `ADCRS_SMP_W];
		end
		case (code)
			3'h0: sample_cycles = `ADCRS_SMP_CYC_0;
			3'h1: sample_cycles = `ADCRS_SMP_CYC_1;
			3'h2: sample_cycles = `ADCRS_SMP_CYC_2;
			3'h3: sample_cycles = `ADCRS_SMP_CYC_3;
			3'h4: sample_cycles = `ADCRS_SMP_CYC_4;
			3'h5: sample_cycles = `ADCRS_SMP_CYC_5;
			3'h6: sample_cycles = `ADCRS_SMP_CYC_6;
			default: sample_cycles = `ADCRS_SMP_CYC_7;
		endcase
	endfunction

	adcrs_trig u_trig (
		.clk(clk),
		.sys_rst(sys_rst),
		.hold_clear(~converter_enable),
		.hw_trigger_select(hw_trigger_select),
		.timer_a_compare_0(timer_a_compare_0),
		.timer_a_compare_1(timer_a_compare_1),
		.timer_a_compare_2(timer_a_compare_2),
		.timer_b_compare_1(timer_b_compare_1),
		.timer_c_trigger_out(timer_c_trigger_out),
		.timer_d_compare_3(timer_d_compare_3),
		.ext_line_eleven(ext_line_eleven),
		.rise(hw_rise)
	);

	// triggers arriving while a conversion runs are dropped
	assign trigger = converter_enable & (soft_routine_start | (hw_trigger_enable & hw_rise));

	assign cur_channel = slot_channel(sequence_slots, slot);
	assign chan_end = (state == adcrs_pkg::ADCRS_CONVERT) && (cnt == 9'h000);

	// single mode only ever uses the first slot
	assign seq_last = (!scan_enable && !discontinuous_enable) || (slot == sequence_length);

	always_comb begin
		next_state = state;
		next_slot = slot;
		next_group_cnt = group_cnt;
		next_cnt = cnt;
		set_done = 1'b0;
		case (state)
			adcrs_pkg::ADCRS_IDLE: begin
				if (trigger) begin
					next_state = adcrs_pkg::ADCRS_SAMPLE;
					next_group_cnt = 3'h0;
					// discontinuous resumes where the last group stopped
					if (!discontinuous_enable) begin
						next_slot = 4'h0;
					end
					next_cnt = sample_cycles(sample_time_regs, slot_channel(sequence_slots, next_slot)) - 9'h001;
				end
			end
			adcrs_pkg::ADCRS_SAMPLE: begin
				if (cnt == 9'h000) begin
					next_state = adcrs_pkg::ADCRS_CONVERT;
					next_cnt = `ADCRS_CONV_CYC - 9'h001;
				end else begin
					next_cnt = cnt - 9'h001;
				end
			end
			adcrs_pkg::ADCRS_CONVERT: begin
				if (cnt != 9'h000) begin
					next_cnt = cnt - 9'h001;
				end else if (discontinuous_enable) begin
					if (seq_last) begin
						set_done = 1'b1;
						next_slot = 4'h0;
						next_state = adcrs_pkg::ADCRS_IDLE;
					end else begin
						next_slot = slot + 4'h1;
						if (group_cnt == group_size) begin
							next_state = adcrs_pkg::ADCRS_IDLE;
						end else begin
							next_group_cnt = group_cnt + 3'h1;
							next_state = adcrs_pkg::ADCRS_SAMPLE;
						end
					end
				end else if (seq_last) begin
					set_done = 1'b1;
					next_slot = 4'h0;
					next_state = repeat_enable ? adcrs_pkg::ADCRS_SAMPLE : adcrs_pkg::ADCRS_IDLE;
				end else begin
					next_slot = slot + 4'h1;
					next_state = adcrs_pkg::ADCRS_SAMPLE;
				end
				if (cnt == 9'h000 && next_state == adcrs_pkg::ADCRS_SAMPLE) begin
					next_cnt = sample_cycles(sample_time_regs, slot_channel(sequence_slots, next_slot)) - 9'h001;
				end
			end
			default: begin
				next_state = adcrs_pkg::ADCRS_IDLE;
			end
		endcase
	end

	assign next_channel = slot_channel(sequence_slots, next_slot);

	// sequencing state; a low enable holds it as after reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= adcrs_pkg::ADCRS_IDLE;
			slot <= 4'h0;
			group_cnt <= 3'h0;
			cnt <= 9'h000;
		end else if (!converter_enable) begin
			state <= adcrs_pkg::ADCRS_IDLE;
			slot <= 4'h0;
			group_cnt <= 3'h0;
			cnt <= 9'h000;
		end else begin
			state <= next_state;
			slot <= next_slot;
			group_cnt <= next_group_cnt;
			cnt <= next_cnt;
		end
	end

	// analog front-end controls come from flops so they never glitch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ana_channel <= 5'h00;
			ana_sample <= 1'b0;
			ana_convert <= 1'b0;
		end else if (!converter_enable) begin
			ana_channel <= 5'h00;
			ana_sample <= 1'b0;
			ana_convert <= 1'b0;
		end else begin
			ana_channel <= next_channel;
			ana_sample <= (next_state == adcrs_pkg::ADCRS_SAMPLE);
			ana_convert <= (next_state == adcrs_pkg::ADCRS_CONVERT);
		end
	end

	// window check on the raw result, independent of alignment
	assign outside = (ana_result > high_limit_reg) || (ana_result < low_limit_reg);
	assign watch_hit = routine_watch_enable && (!single_channel_watch || cur_channel == watched_channel);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			routine_data <= `ADCRS_DATA_RST;
		end else if (!converter_enable) begin
			routine_data <= `ADCRS_DATA_RST;
		end else if (chan_end) begin
			if (align_select) begin
				routine_data <= {ana_result, `ADCRS_PAD_W'(0)};
			end else begin
				routine_data <= {`ADCRS_PAD_W'(0), ana_result};
			end
		end
	end

	// flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_flag <= 1'b0;
		end else if (!converter_enable) begin
			done_flag <= 1'b0;
		end else if (set_done) begin
			done_flag <= 1'b1;
		end else if (done_flag_clear) begin
			done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			limit_violation_flag <= 1'b0;
		end else if (!converter_enable) begin
			limit_violation_flag <= 1'b0;
		end else if (chan_end && watch_hit && outside) begin
			limit_violation_flag <= 1'b1;
		end else if (limit_flag_clear) begin
			limit_violation_flag <= 1'b0;
		end
	end

	// one-cycle request, aligned with the data register update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dma_request <= 1'b0;
		end else begin
			dma_request <= converter_enable & dma_enable & chan_end;
		end
	end

	assign irq = (done_flag & done_irq_enable) | (limit_violation_flag & limit_irq_enable);
	assign busy = (state != adcrs_pkg::ADCRS_IDLE);

endmodule
`default_nettype wire

// [adcrs_chk.sv]
// port-level assertions of the routine sequencer
// assumes bind onto adcrs_seq; one clock, async active-high reset
`timescale 1ns/100ps
`default_nettype none
module adcrs_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic converter_enable,
	input wire logic repeat_enable,
	input wire logic discontinuous_enable,
	input wire logic [53:0] sample_time_regs,
	input wire logic soft_routine_start,
	input wire logic align_select,
	input wire logic dma_enable,
	input wire logic done_irq_enable,
	input wire logic done_flag_clear,
	input wire logic limit_irq_enable,
	input wire logic [4:0] ana_channel,
	input wire logic ana_sample,
	input wire logic ana_convert,
	input wire logic [15:0] routine_data,
	input wire logic done_flag,
	input wire logic limit_violation_flag,
	input wire logic dma_request,
	input wire logic irq,
	input wire logic busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [2:0] code;
	// only channels 0..17 are driven by the bench, so the slice stays in range
	assign code = sample_time_regs[ana_channel*3 +: 3];
	sequence s_conv;
		ana_convert[*8] ##1 ana_convert[*5] ##1 !ana_convert;
	endsequence
	sequence s_smp0;
		ana_sample[*2] ##1 (ana_convert && !ana_sample);
	endsequence
	sequence s_smp1;
		ana_sample[*4] ##1 (ana_convert && !ana_sample);
	endsequence
	AST_CONV: assert property ($rose(ana_convert) |-> s_conv)
		else $error("convert phase length wrong");
	AST_SMP0: assert property ($rose(ana_sample) && code == 3'h0 |-> s_smp0)
		else $error("sample phase not 2 cycles");
	AST_SMP1: assert property ($rose(ana_sample) && code == 3'h1 |-> s_smp1)
		else $error("sample phase not 4 cycles");
	AST_START: assert property (converter_enable && !busy && soft_routine_start |=> busy && ana_sample)
		else $error("soft start not taken");
	AST_OFF: assert property (!converter_enable |=> !busy && !done_flag && routine_data == 16'h0000)
		else $error("disabled converter not in reset");
	// controls as seen at the capture edge, one cycle before the convert phase is seen to end
	AST_DMA: assert property ($fell(ana_convert) && $past(dma_enable) |-> dma_request ##1 !dma_request)
		else $error("transfer request missing");
	AST_ALIGN: assert property ($fell(ana_convert) |->
		($past(align_select) ? routine_data[3:0] == 4'h0 : routine_data[15:12] == 4'h0))
		else $error("padding bits not zero");
	AST_DCLR: assert property (done_flag && done_flag_clear && !ana_convert |=> !done_flag)
		else $error("done flag not cleared");
	AST_IRQ: assert property (irq == (done_flag && done_irq_enable || limit_violation_flag && limit_irq_enable))
		else $error("irq mismatch");
	AST_REP: assert property ($fell(ana_convert) && $past(repeat_enable) && !$past(discontinuous_enable)
		|-> ana_sample)
		else $error("repeat did not restart");
endmodule
`default_nettype wire

// [adcrs_far.sv]
// far side: timer and line trigger sources plus the analog result source
// assumes triggers synchronous to clk; result read in the last convert cycle
`timescale 1ns/100ps
`default_nettype none
module adcrs_far (
	input wire logic clk,
	input wire logic [4:0] ana_channel,
	input wire logic ana_convert,
	output logic [11:0] ana_result,
	output logic [6:0] trig
);
	logic [11:0] noise = 12'hA5A;
	initial trig = 7'h00;
	// churns outside conversion so a mistimed capture cannot match
	always @(posedge clk) noise <= noise + 12'h5A5;
	assign ana_result = ana_convert ? 12'(ana_channel) * 12'h0C8 : noise;
	task automatic pulse(input int i);
		@(posedge clk) trig[i] <= 1'b1;
		@(posedge clk) trig[i] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench of the routine sequencer with its far-side model
// assumes adcrs_seq, adcrs_chk and adcrs_far compiled before this file
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk, sys_rst, converter_enable, scan_enable, repeat_enable, discontinuous_enable;
	logic hw_trigger_enable, soft_routine_start, align_select, dma_enable, done_irq_enable, done_flag_clear;
	logic routine_watch_enable, single_channel_watch, limit_irq_enable, limit_flag_clear;
	logic ana_sample, ana_convert, done_flag, limit_violation_flag, dma_request, irq, busy;
	logic [2:0] group_size, hw_trigger_select;
	logic [3:0] sequence_length;
	logic [79:0] sequence_slots;
	logic [53:0] sample_time_regs;
	logic [4:0] watched_channel, ana_channel;
	logic [11:0] high_limit_reg, low_limit_reg, ana_result;
	logic [15:0] routine_data;
	wire logic [6:0] trig;
	wire logic timer_a_compare_0, timer_a_compare_1, timer_a_compare_2, timer_b_compare_1;
	wire logic timer_c_trigger_out, timer_d_compare_3, ext_line_eleven;
	logic [11:0] wd [4] = '{12'h297, 12'h29A, 12'h100, 12'h001};
	int n_errors = 0;
	int checks = 0;
	int n, nd, nf;
	assign {ext_line_eleven, timer_d_compare_3, timer_c_trigger_out, timer_b_compare_1,
		timer_a_compare_2, timer_a_compare_1, timer_a_compare_0} = trig;
	adcrs_seq dut (
		.clk(clk), .sys_rst(sys_rst), .converter_enable(converter_enable), .scan_enable(scan_enable),
		.repeat_enable(repeat_enable), .discontinuous_enable(discontinuous_enable), .group_size(group_size),
		.sequence_length(sequence_length), .sequence_slots(sequence_slots), .sample_time_regs(sample_time_regs),
		.hw_trigger_enable(hw_trigger_enable), .hw_trigger_select(hw_trigger_select),
		.soft_routine_start(soft_routine_start), .timer_a_compare_0(timer_a_compare_0),
		.timer_a_compare_1(timer_a_compare_1), .timer_a_compare_2(timer_a_compare_2),
		.timer_b_compare_1(timer_b_compare_1), .timer_c_trigger_out(timer_c_trigger_out),
		.timer_d_compare_3(timer_d_compare_3), .ext_line_eleven(ext_line_eleven), .align_select(align_select),
		.dma_enable(dma_enable), .done_irq_enable(done_irq_enable), .done_flag_clear(done_flag_clear),
		.routine_watch_enable(routine_watch_enable), .single_channel_watch(single_channel_watch),
		.watched_channel(watched_channel), .high_limit_reg(high_limit_reg), .low_limit_reg(low_limit_reg),
		.limit_irq_enable(limit_irq_enable), .limit_flag_clear(limit_flag_clear), .ana_result(ana_result),
		.ana_channel(ana_channel), .ana_sample(ana_sample), .ana_convert(ana_convert),
		.routine_data(routine_data), .done_flag(done_flag), .limit_violation_flag(limit_violation_flag),
		.dma_request(dma_request), .irq(irq), .busy(busy)
	);
	adcrs_far far (.clk(clk), .ana_channel(ana_channel), .ana_convert(ana_convert), .ana_result(ana_result), .trig(trig));
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic go;
		@(posedge clk) soft_routine_start <= 1'b1;
		@(posedge clk) soft_routine_start <= 1'b0;
	endtask
	task automatic clr(input bit lim);
		@(posedge clk) {limit_flag_clear, done_flag_clear} <= {lim, !lim};
		@(posedge clk) {limit_flag_clear, done_flag_clear} <= 2'b00;
	endtask
	// counts cycles, transfer pulses and done cycles until busy has come and gone
	task automatic idle;
		bit seen_busy;
		{n, nd, nf, seen_busy} = '0;
		while (n < 3000) begin
			@(posedge clk);
			#1;
			n++;
			nd += dma_request;
			nf += done_flag;
			seen_busy |= busy;
			if (seen_busy && !busy)
				return;
		end
		n_errors++;
		end_sim;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		{converter_enable, scan_enable, repeat_enable, discontinuous_enable, group_size, hw_trigger_select,
			sequence_length, sequence_slots, sample_time_regs, hw_trigger_enable, soft_routine_start,
			align_select, dma_enable, done_irq_enable, done_flag_clear, routine_watch_enable,
			single_channel_watch, limit_irq_enable, limit_flag_clear, watched_channel,
			high_limit_reg, low_limit_reg} = '0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		{converter_enable, done_irq_enable, dma_enable} <= 3'b111;
		sequence_slots[4:0] <= 5'h05;
		@(posedge clk);
		#1 chk(routine_data, 16'h0000);
		chk(16'({done_flag, busy}), 16'h0000);
		go;
		idle;
		chk(16'(n), 16'h000F);
		chk(routine_data, 16'h03E8);
		chk(16'({nf[3:0], nd[3:0], done_flag, irq}), 16'h0047);
		@(posedge clk) converter_enable <= 1'b0;
		go;
		#1 chk(16'({done_flag, busy, routine_data[11:0]}), 16'h0000);
		@(posedge clk) {converter_enable, align_select, hw_trigger_enable} <= 3'b111;
		for (int i = 0; i < 7; i++) begin
			@(posedge clk) hw_trigger_select <= 3'(i);
			far.pulse(i);
			idle;
			chk(routine_data, 16'h3E80);
			clr(0);
			#1 chk(16'(done_flag), 16'h0000);
		end
		@(posedge clk) hw_trigger_enable <= 1'b0;
		far.pulse(6);
		repeat (4) @(posedge clk);
		#1 chk(16'({busy, done_flag}), 16'h0000);
		@(posedge clk) {align_select, scan_enable, sequence_length} <= 6'h12;
		sequence_slots[14:0] <= 15'h0C41;
		sample_time_regs[11:9] <= 3'h1;
		go;
		idle;
		// channels 1, 2, 3: (2 + 13) + (2 + 13) + (4 + 13) busy cycles, no gap between channels
		chk(16'(n), 16'h002F);
		chk(routine_data, 16'h0258);
		chk(16'({nd[3:0], nf[3:0]}), 16'h0031);
		clr(0);
		{scan_enable, discontinuous_enable, group_size} <= 5'h09;
		for (int k = 0; k < 3; k++) begin
			go;
			idle;
			chk(routine_data, k == 1 ? 16'h0258 : 16'h0190);
			chk(16'(n), k == 1 ? 16'h0011 : 16'h001E);
			chk(16'(nf), k == 1 ? 16'h0001 : 16'h0000);
			clr(0);
		end
		{discontinuous_enable, scan_enable, repeat_enable, sequence_length} <= 7'h31;
		go;
		nd = 0;
		repeat (52) begin
			@(posedge clk);
			#1 nd += dma_request;
		end
		chk(16'(nd), 16'h0003);
		@(posedge clk) repeat_enable <= 1'b0;
		idle;
		chk(routine_data, 16'h0190);
		@(posedge clk) {scan_enable, done_irq_enable, align_select, routine_watch_enable, limit_irq_enable} <= 5'h07;
		{high_limit_reg, low_limit_reg} <= {12'h300, 12'h100};
		foreach (wd[k]) begin
			@(posedge clk) {sequence_slots[4:0], watched_channel, single_channel_watch} <= wd[k][11:1];
			go;
			idle;
			chk(16'({limit_violation_flag, irq}), 16'({2{wd[k][0]}}));
			clr(1);
			#1 chk(16'(limit_violation_flag), 16'h0000);
		end
		end_sim;
	end
endmodule
bind adcrs_seq adcrs_chk chk (
	.clk(clk), .sys_rst(sys_rst), .converter_enable(converter_enable), .repeat_enable(repeat_enable),
	.discontinuous_enable(discontinuous_enable), .sample_time_regs(sample_time_regs),
	.soft_routine_start(soft_routine_start), .align_select(align_select), .dma_enable(dma_enable),
	.done_irq_enable(done_irq_enable), .done_flag_clear(done_flag_clear), .limit_irq_enable(limit_irq_enable),
	.ana_channel(ana_channel), .ana_sample(ana_sample), .ana_convert(ana_convert), .routine_data(routine_data),
	.done_flag(done_flag), .limit_violation_flag(limit_violation_flag), .dma_request(dma_request), .irq(irq),
	.busy(busy)
);
`default_nettype wire
